/* hw/ssv_pkg.sv */
// Constants shared by the supply supervisor and chip-enable gate
package ssv_pkg;

  // Clock rate
  localparam int unsigned CLK_KHZ = 250000;

  // Times in their own units
  localparam int unsigned RST_HOLD_MS = 140;
  localparam int unsigned WD_TIMEOUT_MS = 1000;
  localparam int unsigned CE_HOLD_NS = 1000;
  localparam int unsigned DEB_US = 10;

  // Cycle counts derived from the times (least times round up)
  localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_KHZ;
  localparam int unsigned CE_HOLD_CYC = (CE_HOLD_NS * CLK_KHZ + 999999) / 1000000;
  localparam int unsigned DEB_CYC = (DEB_US * CLK_KHZ + 999) / 1000;

  // Counter widths
  localparam int unsigned CE_CNT_W = 8;
  localparam int unsigned DEB_CNT_W = 12;
  localparam logic [CE_CNT_W-1:0] CE_HOLD_LAST = CE_CNT_W'(CE_HOLD_CYC - 1);
  localparam logic [DEB_CNT_W-1:0] DEB_LAST = DEB_CNT_W'(DEB_CYC - 1);

  // Synchronised input vector
  localparam int unsigned N_IN = 7;
  localparam int unsigned IN_SUP_LOW = 0;
  localparam int unsigned IN_BELOW_CELL = 1;
  localparam int unsigned IN_MR = 2;
  localparam int unsigned IN_AUX_LOW = 3;
  localparam int unsigned IN_PF_LOW = 4;
  localparam int unsigned IN_WDI = 5;
  localparam int unsigned IN_CE = 6;
  localparam logic [N_IN-1:0] SYNC_RST = 7'h45;

  // Register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;

  // Control fields
  localparam int unsigned CTRL_WD_EN = 0;
  localparam int unsigned CTRL_FORCE = 1;
  localparam logic [1:0] CTRL_RST = 2'h1;

  // Status fields
  localparam int unsigned ST_RESET = 0;
  localparam int unsigned ST_BACKUP = 1;
  localparam int unsigned ST_PFO = 2;
  localparam int unsigned ST_SUP_LOW = 3;
  localparam int unsigned ST_MR = 4;
  localparam int unsigned ST_AUX = 5;
  localparam int unsigned ST_POWERED = 6;
  localparam int unsigned ST_CE_LO = 7;

  typedef enum logic [1:0] {
    CE_PASS = 2'b00,
    CE_FINISH = 2'b01,
    CE_BLOCK = 2'b10
  } ssv_ce_state_t;

endpackage

/* hw/ssv_supervisor.sv */
// Reset supervisor, watchdog, battery-backup decision and chip-enable gate
// How it works
// - Outside reset, chip-enable output follows chip-enable input.
// - Enable idle at reset onset keeps output high for the whole reset.
// - Enable active at reset onset stays low 1us, then forced high.
// - Blocked chip-enable output is driven high, never released.
// - Backup mode needs supply below threshold and below the cell.
// - Backup mode holds reset and flag, ignores inputs, blocks enable, warns.
// - Nothing starts until the main supply has once been valid.
// - Manual reset low asserts reset, held 140ms after release.
// - Manual reset input is debounced internally.
// - Any kick edge, or 100ns pulse, restarts the watchdog.
// - Kick static past timeout gives a reset pulse of hold length.
// - Watchdog clears while reset is asserted and on every kick edge.
// - Static kick repeats the reset pulse every timeout.
// - Backup flag is push-pull high exactly during backup mode.
// - Auxiliary comparator low asserts reset.
// - Power-fail comparator low drives the warning output low.
// - Supply below threshold forces the warning low.
// - Supply below threshold holds reset, then 140ms after recovery.
// - Reset and warning outputs share one push-pull/open-drain variant.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ssv_supervisor #(
  parameter int unsigned HOLD_CYC = ssv_pkg::RST_HOLD_CYC,
  parameter int unsigned WD_CYC = ssv_pkg::WD_TIMEOUT_CYC,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ssv_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_low,
  input wire logic supply_below_cell,
  input wire logic manual_reset_n,
  input wire logic aux_supply_sense,
  input wire logic power_fail_sense,
  input wire logic watchdog_kick_in,
  input wire logic chip_enable_in_n,
  output logic chip_enable_out_n,
  output logic backup_mode_flag,
  output logic reset_out_n,
  output logic reset_oe_n,
  output logic power_fail_warn_n,
  output logic power_fail_oe_n
);

  // Synchroniser, three stages, value taken when stages two and three agree
  logic [ssv_pkg::N_IN-1:0] s1_r, s2_r, s3_r, cln_r;
  wire [ssv_pkg::N_IN-1:0] raw_w = {chip_enable_in_n, watchdog_kick_in, power_fail_sense,
    aux_supply_sense, manual_reset_n, supply_below_cell, supply_low};
  wire [ssv_pkg::N_IN-1:0] agree_w = ~(s2_r ^ s3_r);
  wire [ssv_pkg::N_IN-1:0] cln_nxt = (s3_r & agree_w) | (cln_r & ~agree_w);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= ssv_pkg::SYNC_RST;
      s2_r <= ssv_pkg::SYNC_RST;
      s3_r <= ssv_pkg::SYNC_RST;
      cln_r <= ssv_pkg::SYNC_RST;
    end else if (clk_en) begin
      s1_r <= raw_w;
      s2_r <= s1_r;
      s3_r <= s2_r;
      cln_r <= cln_nxt;
    end
  end

  wire sup_low_w = cln_r[ssv_pkg::IN_SUP_LOW];
  wire below_cell_w = cln_r[ssv_pkg::IN_BELOW_CELL];
  wire aux_low_w = cln_r[ssv_pkg::IN_AUX_LOW];
  wire pf_low_w = cln_r[ssv_pkg::IN_PF_LOW];
  wire wdi_w = cln_r[ssv_pkg::IN_WDI];
  wire ce_in_w = cln_r[ssv_pkg::IN_CE];

  // Power-up latch: a cell alone never starts the part
  logic powered_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powered_r <= 1'b0;
    end else if (clk_en && !sup_low_w) begin
      powered_r <= 1'b1;
    end
  end

  wire backup_w = powered_r & sup_low_w & below_cell_w;

  // Manual reset debounce: a level must stand for the whole interval
  logic mr_db_r;
  logic [ssv_pkg::DEB_CNT_W-1:0] deb_cnt_r;
  wire mr_diff_w = cln_r[ssv_pkg::IN_MR] != mr_db_r;
  wire deb_done_w = mr_diff_w && (deb_cnt_r == ssv_pkg::DEB_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_db_r <= 1'b1;
      deb_cnt_r <= '0;
    end else if (clk_en) begin
      deb_cnt_r <= (mr_diff_w && !deb_done_w) ? deb_cnt_r + 1'b1 : '0;
      if (deb_done_w) begin
        mr_db_r <= cln_r[ssv_pkg::IN_MR];
      end
    end
  end

  // Control register fields
  logic [1:0] ctrl_r;
  wire wd_en_w = ctrl_r[ssv_pkg::CTRL_WD_EN];
  wire force_w = ctrl_r[ssv_pkg::CTRL_FORCE];

  // Watchdog
  logic [31:0] wd_cnt_r;
  logic wdi_prev_r;
  logic rst_r;
  wire kick_w = wdi_w != wdi_prev_r;
  wire wd_fire_w = wd_en_w && !rst_r && !kick_w && !backup_w && (wd_cnt_r == WD_CYC - 1);
  wire wd_clr_w = rst_r || kick_w || !wd_en_w || backup_w || wd_fire_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_r <= '0;
      wdi_prev_r <= 1'b0;
    end else if (clk_en) begin
      wdi_prev_r <= wdi_w;
      // Clearing on reset is what makes a static kick repeat pulses
      wd_cnt_r <= wd_clr_w ? '0 : wd_cnt_r + 1'b1;
    end
  end

  // Reset hold timer
  logic [31:0] hold_cnt_r;
  wire mr_cause_w = !mr_db_r && !backup_w;
  wire aux_cause_w = aux_low_w && !backup_w;
  wire cause_w = !powered_r || sup_low_w || mr_cause_w || aux_cause_w || force_w ||
    wd_fire_w;
  wire [31:0] hold_nxt = cause_w ? '0 :
    (hold_cnt_r != HOLD_CYC) ? hold_cnt_r + 1'b1 : hold_cnt_r;
  wire rst_nxt = cause_w || (hold_nxt != HOLD_CYC);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_r <= '0;
      rst_r <= 1'b1;
    end else if (clk_en) begin
      hold_cnt_r <= hold_nxt;
      rst_r <= rst_nxt;
    end
  end

  // Chip-enable gate
  ssv_pkg::ssv_ce_state_t ce_state_r, ce_state_nxt;
  logic [ssv_pkg::CE_CNT_W-1:0] ce_cnt_r;

  always_comb begin
    ce_state_nxt = ce_state_r;
    case (ce_state_r)
      ssv_pkg::CE_PASS: begin
        if (backup_w) begin
          ce_state_nxt = ssv_pkg::CE_BLOCK;
        end else if (rst_nxt) begin
          ce_state_nxt = ce_in_w ? ssv_pkg::CE_BLOCK : ssv_pkg::CE_FINISH;
        end
      end
      ssv_pkg::CE_FINISH: begin
        if (backup_w || ce_cnt_r == ssv_pkg::CE_HOLD_LAST) begin
          ce_state_nxt = ssv_pkg::CE_BLOCK;
        end
      end
      ssv_pkg::CE_BLOCK: begin
        if (!rst_nxt) begin
          ce_state_nxt = ssv_pkg::CE_PASS;
        end
      end
      default: ce_state_nxt = ssv_pkg::CE_BLOCK;
    endcase
  end

  // Blocked path drives high, never floats
  wire ce_out_nxt = (ce_state_nxt == ssv_pkg::CE_PASS) ? ce_in_w :
    (ce_state_nxt == ssv_pkg::CE_FINISH) ? 1'b0 : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_state_r <= ssv_pkg::CE_BLOCK;
      ce_cnt_r <= '0;
      chip_enable_out_n <= 1'b1;
    end else if (clk_en) begin
      ce_state_r <= ce_state_nxt;
      ce_cnt_r <= (ce_state_r == ssv_pkg::CE_FINISH && ce_state_nxt == ssv_pkg::CE_FINISH) ?
        ce_cnt_r + 1'b1 : '0;
      chip_enable_out_n <= ce_out_nxt;
    end
  end

  // Pin drivers; open-drain only pulls low and releases otherwise
  wire pfo_low_nxt = sup_low_w || pf_low_w;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n <= 1'b0;
      reset_oe_n <= 1'b0;
      power_fail_warn_n <= 1'b0;
      power_fail_oe_n <= 1'b0;
      backup_mode_flag <= 1'b0;
    end else if (clk_en) begin
      reset_out_n <= OPEN_DRAIN ? 1'b0 : !rst_nxt;
      reset_oe_n <= OPEN_DRAIN ? !rst_nxt : 1'b0;
      power_fail_warn_n <= OPEN_DRAIN ? 1'b0 : !pfo_low_nxt;
      power_fail_oe_n <= OPEN_DRAIN ? !pfo_low_nxt : 1'b0;
      backup_mode_flag <= backup_w;
    end
  end

  // APB slave: one wait state, answer registered
  wire acc_w = psel && penable;
  wire hit_ctrl_w = paddr == ssv_pkg::CTRL_OFS;
  wire hit_stat_w = paddr == ssv_pkg::STATUS_OFS;
  wire bad_w = !(hit_ctrl_w || (hit_stat_w && !pwrite));
  wire wr_ctrl_w = acc_w && pready && pwrite && hit_ctrl_w;
  wire [31:0] status_w = {24'h000000, ce_state_r == ssv_pkg::CE_FINISH, powered_r,
    aux_low_w, !mr_db_r, sup_low_w, pfo_low_nxt, backup_w, rst_r};
  wire [31:0] rdata_w = hit_ctrl_w ? {30'h00000000, ctrl_r} :
    hit_stat_w ? status_w : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_r <= ssv_pkg::CTRL_RST;
    end else if (clk_en) begin
      pready <= acc_w && !pready;
      pslverr <= acc_w && !pready && bad_w;
      prdata <= (acc_w && !pready && !pwrite) ? rdata_w : 32'h00000000;
      if (wr_ctrl_w) begin
        ctrl_r <= pwdata[1:0];
      end
    end
  end

  // Checks
  wire rst_lvl_w = reset_oe_n ? 1'b1 : reset_out_n;
  wire pfo_lvl_w = power_fail_oe_n ? 1'b1 : power_fail_warn_n;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !clk_en);

  sequence finish_start_s;
    ce_state_r == ssv_pkg::CE_PASS && rst_nxt && !ce_in_w && !backup_w;
  endsequence

  sequence finish_window_s;
    (!chip_enable_out_n) [*8] ##[1:300] chip_enable_out_n;
  endsequence

  ce_pass_a: assert property (
    (ce_state_r == ssv_pkg::CE_PASS && !rst_nxt && !backup_w) |=>
      chip_enable_out_n == $past(ce_in_w))
    else $error("chip enable not passed through");

  ce_block_a: assert property (
    (ce_state_r == ssv_pkg::CE_BLOCK) |-> chip_enable_out_n)
    else $error("blocked chip enable not high");

  ce_finish_a: assert property (
    finish_start_s |=> finish_window_s)
    else $error("chip enable finish window wrong");

  backup_rst_a: assert property (
    backup_mode_flag |-> !rst_lvl_w && !pfo_lvl_w)
    else $error("backup without reset or warning");

  backup_flag_a: assert property (
    (sup_low_w && below_cell_w && powered_r) |=> backup_mode_flag)
    else $error("backup flag missing");

  mr_rst_a: assert property (
    $fell(mr_db_r) && !backup_w |=> !rst_lvl_w [*8])
    else $error("manual reset not held");

  wd_clear_a: assert property (
    rst_r |=> wd_cnt_r == 32'h00000000)
    else $error("watchdog not cleared in reset");

  wd_fire_a: assert property (
    wd_fire_w |=> rst_r && !rst_lvl_w ##1 rst_r [*7])
    else $error("watchdog expiry gave no reset");

  aux_rst_a: assert property (
    aux_low_w && !backup_w |=> !rst_lvl_w)
    else $error("aux comparator ignored");

  pfo_warn_a: assert property (
    pf_low_w |=> !pfo_lvl_w)
    else $error("power fail warning missing");

  sup_hold_a: assert property (
    $fell(sup_low_w) && powered_r |=> rst_r [*8])
    else $error("supply recovery released reset early");

  sequence kick_seen_s;
    kick_w && !backup_w;
  endsequence

  sequence rst_done_s;
    $fell(rst_r);
  endsequence

  kick_clear_a: assert property (
    kick_seen_s |=> wd_cnt_r == 32'h00000000)
    else $error("kick did not restart watchdog");

  wd_bound_a: assert property (
    wd_cnt_r < WD_CYC)
    else $error("watchdog ran past timeout");

  hold_done_a: assert property (
    rst_done_s |-> hold_cnt_r == HOLD_CYC)
    else $error("reset released before hold");

  hold_bound_a: assert property (
    hold_cnt_r <= HOLD_CYC)
    else $error("hold counter overrun");

  ce_bound_a: assert property (
    ce_cnt_r <= ssv_pkg::CE_HOLD_LAST)
    else $error("chip enable hold overrun");

  mr_deb_a: assert property (
    $changed(mr_db_r) |-> $past(deb_cnt_r) == ssv_pkg::DEB_LAST)
    else $error("manual reset taken before debounce");

  backup_ce_a: assert property (
    backup_w |=> chip_enable_out_n)
    else $error("enable not blocked in backup");

  backup_cond_a: assert property (
    !(sup_low_w && below_cell_w) |=> !backup_mode_flag)
    else $error("backup without both conditions");

  flag_clear_a: assert property (
    !backup_w |=> !backup_mode_flag)
    else $error("backup flag stuck high");

  cold_start_a: assert property (
    !powered_r |=> !rst_lvl_w && !backup_mode_flag)
    else $error("started without main supply");

  sup_rst_a: assert property (
    sup_low_w |=> !rst_lvl_w)
    else $error("reset not held at low supply");

  sup_pfo_a: assert property (
    sup_low_w |=> !pfo_lvl_w)
    else $error("warning not forced at low supply");

  pfo_clear_a: assert property (
    !sup_low_w && !pf_low_w |=> pfo_lvl_w)
    else $error("warning without cause");

  drive_kind_a: assert property (
    OPEN_DRAIN ? (!reset_out_n && !power_fail_warn_n) : (!reset_oe_n && !power_fail_oe_n))
    else $error("output drive variant mixed");

endmodule // ssv_supervisor

/* tb/ssv_cpu_model.sv */
// Processor and RAM-select model on the far side of the supervisor
`timescale 1ns/1ps
module ssv_cpu_model (
  input wire logic pclk,
  input wire logic rst_pin,
  input wire logic kick_en,
  input wire logic ce_req,
  output logic watchdog_kick_in,
  output logic chip_enable_in_n
);
  int kcnt;
  initial begin
    watchdog_kick_in = 1'b0;
    kcnt = 0;
  end
  // A processor held in reset runs no code, so it cannot kick
  always @(posedge pclk) begin
    kcnt <= (kcnt == 30) ? 0 : kcnt + 1;
    if (kick_en && rst_pin && kcnt == 30) begin
      watchdog_kick_in <= ~watchdog_kick_in;
    end
  end
  assign chip_enable_in_n = ~ce_req;
endmodule // ssv_cpu_model

/* tb/supply_supervisor_ce_gate_tb.sv */
// Self-checking bench for the supply supervisor with chip-enable gate
`timescale 1ns/1ps
module supply_supervisor_ce_gate_tb;
  // Short counts keep the run brief
  localparam int HOLD = 40;
  localparam int WD = 100;
  localparam int CEH = ssv_pkg::CE_HOLD_CYC;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, kick_en, ce_req, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic supply_low, supply_below_cell, manual_reset_n, aux_supply_sense, power_fail_sense;
  logic watchdog_kick_in, chip_enable_in_n, chip_enable_out_n, backup_mode_flag;
  logic reset_out_n, reset_oe_n, power_fail_warn_n, power_fail_oe_n, rst_pin, pf_pin;
  int err_total, n_checks, n;
  assign rst_pin = reset_oe_n ? 1'b1 : reset_out_n;
  assign pf_pin = power_fail_oe_n ? 1'b1 : power_fail_warn_n;
  ssv_supervisor #(.HOLD_CYC(HOLD), .WD_CYC(WD)) uut (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .supply_low, .supply_below_cell, .manual_reset_n, .aux_supply_sense,
    .power_fail_sense, .watchdog_kick_in, .chip_enable_in_n, .chip_enable_out_n,
    .backup_mode_flag, .reset_out_n, .reset_oe_n, .power_fail_warn_n, .power_fail_oe_n
  );
  ssv_cpu_model cpu (.pclk, .rst_pin, .kick_en, .ce_req, .watchdog_kick_in,
    .chip_enable_in_n);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic chk(input logic a, input logic e, input string m);
    n_checks++;
    if (a !== e) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, n_checks);
    if (err_total == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Cycles until the reset pin shows lvl, left in n
  task automatic wait_rst(input logic lvl, input int lim);
    n = 0;
    while (rst_pin !== lvl) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        chk(1'b0, 1'b1, "reset pin wait timed out");
        summarize();
      end
    end
  endtask
  // Cycles with reset pin low, left in n
  task automatic watch(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      n += (rst_pin !== 1'b1);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20 && pready !== 1'b1; i++) begin
      @(posedge pclk);
    end
    if (pready !== 1'b1) begin
      chk(1'b0, 1'b1, "bus answer timed out");
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {aux_supply_sense, power_fail_sense, ce_req} = '0;
    clk_en = 1'b1;
    {supply_low, supply_below_cell, manual_reset_n, kick_en} = 4'hf;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h2327));
    repeat (16) @(posedge pclk);
    chk(rst_pin, 1'b0, "reset pin high during reset");
    chk(chip_enable_out_n, 1'b1, "enable out low during reset");
    presetn <= 1'b1;
    repeat (30) @(posedge pclk);
    chk(backup_mode_flag, 1'b0, "backup entered from cell only");
    chk(rst_pin, 1'b0, "started from cell only");
    supply_low <= 1'b0;
    supply_below_cell <= 1'b0;
    wait_rst(1'b1, HOLD + 20);
    chk(n >= HOLD, 1'b1, "power-up hold short");
    apb(1'b0, ssv_pkg::CTRL_OFS, 32'h0);
    chk(rd[1:0] === ssv_pkg::CTRL_RST, 1'b1, "control reset value");
    apb(1'b1, ssv_pkg::CTRL_OFS, ($urandom() & 32'hffff_fffc) | 32'h1);
    chk(err, 1'b0, "control write refused");
    apb(1'b1, ssv_pkg::STATUS_OFS, 32'hffff_ffff);
    chk(err, 1'b1, "status write accepted");
    apb(1'b0, 12'h0f0, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, 1'b1, "unmapped read answered");
    apb(1'b0, ssv_pkg::STATUS_OFS, 32'h0);
    chk(rd[ssv_pkg::ST_POWERED] === 1'b1 && rd[ssv_pkg::ST_RESET] === 1'b0, 1'b1, "status");
    apb(1'b1, ssv_pkg::CTRL_OFS, 32'h3);
    wait_rst(1'b0, 20);
    apb(1'b1, ssv_pkg::CTRL_OFS, 32'h1);
    wait_rst(1'b1, HOLD + 20);
    chk(n >= HOLD, 1'b1, "forced reset hold short");
    for (int i = 0; i < 8; i++) begin
      ce_req <= 1'($urandom());
      repeat (10) @(posedge pclk);
      chk(chip_enable_out_n, ~ce_req, "enable not passed through");
    end
    ce_req <= 1'b1;
    repeat (10) @(posedge pclk);
    aux_supply_sense <= 1'b1;
    wait_rst(1'b0, 20);
    n = 0;
    while (chip_enable_out_n === 1'b0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(n >= CEH - 3 && n <= CEH + 3, 1'b1, "enable finish hold");
    ce_req <= 1'b0;
    repeat (10) @(posedge pclk);
    ce_req <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(chip_enable_out_n, 1'b1, "enable leaked in reset");
    aux_supply_sense <= 1'b0;
    wait_rst(1'b1, HOLD + 20);
    chk(n >= HOLD, 1'b1, "aux reset hold short");
    ce_req <= 1'b0;
    repeat (10) @(posedge pclk);
    aux_supply_sense <= 1'b1;
    wait_rst(1'b0, 20);
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge pclk);
      ce_req <= i[2];
      n += (chip_enable_out_n !== 1'b1);
    end
    chk(n == 0, 1'b1, "enable low after idle onset");
    aux_supply_sense <= 1'b0;
    ce_req <= 1'b0;
    wait_rst(1'b1, HOLD + 20);
    // Bounces far shorter than the debounce window must not reset
    for (int i = 0; i < 6; i++) begin
      manual_reset_n <= i[0];
      watch(50);
      chk(n == 0, 1'b1, "bounce gave reset");
    end
    manual_reset_n <= 1'b0;
    repeat (2600) @(posedge pclk);
    chk(rst_pin, 1'b0, "manual reset ignored");
    manual_reset_n <= 1'b1;
    wait_rst(1'b1, HOLD + 2600);
    chk(n >= HOLD, 1'b1, "manual hold short");
    kick_en <= 1'b0;
    wait_rst(1'b0, WD + 40);
    wait_rst(1'b1, HOLD + 10);
    chk(n >= HOLD && n <= HOLD + 2, 1'b1, "watchdog pulse length");
    wait_rst(1'b0, WD + 10);
    chk(n >= WD - 4, 1'b1, "watchdog repeat early");
    wait_rst(1'b1, HOLD + 10);
    apb(1'b1, ssv_pkg::CTRL_OFS, 32'h0);
    watch(WD + 50);
    chk(n == 0, 1'b1, "disabled watchdog fired");
    apb(1'b1, ssv_pkg::CTRL_OFS, 32'h1);
    kick_en <= 1'b1;
    watch(400);
    chk(n == 0, 1'b1, "reset despite kicks");
    clk_en <= 1'b0;
    power_fail_sense <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(pf_pin, 1'b1, "output moved while frozen");
    clk_en <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(pf_pin, 1'b0, "warning not raised");
    power_fail_sense <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(pf_pin, 1'b1, "warning stuck");
    supply_low <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(pf_pin, 1'b0, "warning not forced");
    chk(backup_mode_flag, 1'b0, "backup above cell");
    supply_below_cell <= 1'b1;
    ce_req <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(backup_mode_flag, 1'b1, "backup not entered");
    chk(rst_pin | pf_pin | ~chip_enable_out_n, 1'b0, "backup outputs");
    supply_below_cell <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(backup_mode_flag, 1'b0, "backup flag stuck");
    ce_req <= 1'b0;
    supply_low <= 1'b0;
    wait_rst(1'b1, HOLD + 20);
    chk(n >= HOLD, 1'b1, "supply hold short");
    summarize();
  end
endmodule // supply_supervisor_ce_gate_tb
